/* rtl/dmadts_dest_trigger.sv */
`timescale 1ns/1ps
// How it works
// R1 - Mode 000 holds the destination pointer, 001 steps it per access; 010, 011, 111 reserved.
// R2 - Destination mode writes are ignored while the channel is busy.
// R3 - Mode 100: masked byte compare, low byte is data, high byte is mask.
// R4 - Mode 101: byte equal to low or high pointer byte matches, one-byte bursts only.
// R5 - Mode 110: low byte followed immediately by high byte matches.
// R6 - Eight-bit trigger select; zero leaves only software requests.
// R7 - A selection naming an absent unit never sees a request.
// R8 - Software must not clear or enable the selected source flag's interrupt.
// R9 - Taking a hardware request acknowledges and clears the source flag.
// R10 - Bases: event routing 0x01, input converter 0x10, output converter 0x15.
// R11 - Bases: quad timer 0x40, first dual timer 0x46, second dual timer 0x66.
// R12 - Bases: serial peripheral 0x4a, serial ports 0x4c and 0x6c.
// R13 - Each code is base plus offset and names one request line.
// R14 - Input converter offset 0; output converter offsets 0 and 1 are its channels.
// R15 - Event routing offsets 0, 1, 2 are routing channels 0, 1, 2.
// R16 - Timer offsets: wrap, error, compare A to D; C, D only on quad timer.
// R17 - Serial port offset 0 is receive done, 1 is transmit holding empty.
// R18 - Serial peripheral: both offsets transfer done, or receive done and holding empty buffered.
// R19 - Burst size 0 is one byte, 1 two bytes; byte searches need one byte.
// R20 - Busy sets on start, clears on disable, completion or error.
// R21 - In search modes the pointer pair is the pattern and never moves.
// R22 - A match sets a sticky found flag and ends the transaction.
module dmadts_dest_trigger #(
	parameter logic [dmadts_pkg::NUM_LINES-1:0] LINE_PRESENT = dmadts_pkg::DEFAULT_PRESENT
) (
	// Clock and reset.
	input logic clk,
	input logic nrst,
	// Register port.
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [7:0] reg_rdata,
	// Event routing and converters.
	input logic [2:0] event_req,
	input logic converter_in_req,
	input logic [1:0] converter_out_req,
	// Timers, bit order wrap, error, compare A, B, C, D.
	input logic [5:0] timer_quad_first_req,
	input logic [3:0] timer_dual_first_req,
	input logic [3:0] timer_dual_second_req,
	// Serial peripheral.
	input logic spi_buffered,
	input logic spi_xfer_done,
	input logic spi_receive_done,
	input logic spi_tx_holding_empty,
	// Serial ports, bit 0 receive done, bit 1 transmit holding empty.
	input logic [1:0] serial_port_first_req,
	input logic [1:0] serial_port_second_req,
	// Acknowledge back to the sources, by line index.
	output logic [dmadts_pkg::NUM_LINES-1:0] req_ack,
	// Rest of the channel.
	input logic beat_done,
	input logic xfer_complete,
	input logic xfer_error,
	input logic data_valid,
	input logic [7:0] data_byte,
	output logic transfer_start,
	output logic channel_active_flag,
	output logic search_match,
	output logic [15:0] dest_pointer,
	output logic [2:0] dest_addr_mode,
	output logic burst_size
);

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	dmadts_pkg::dmadts_chan_t state;
	dmadts_pkg::dmadts_chan_t next_state;
	logic enable;
	logic soft_pend;
	logic found;
	logic [7:0] trigger_select;
	logic [dmadts_pkg::NUM_LINES-1:0] line_req;
	logic [dmadts_pkg::NUM_LINES-1:0] line_hit;
	logic hw_request;
	logic spi_line0;
	logic spi_line1;
	logic busy;
	logic idle_start;
	logic chan_end;
	logic wr_ctrl;
	logic wr_status;
	logic wr_mode;
	logic wr_trigger;
	logic wr_low;
	logic wr_high;
	logic soft_transfer_request;
	logic is_search;
	logic mode_invalid;
	logic [7:0] ctrl_value;
	logic [7:0] status_value;
	logic [7:0] next_rdata;
	logic [15:0] next_dest_pointer;
	logic next_soft_pend;
	logic next_found;

	// Serial peripheral lines depend on its buffer mode. [R18]
	assign spi_line0 = spi_buffered ? spi_receive_done : spi_xfer_done;
	assign spi_line1 = spi_buffered ? spi_tx_holding_empty : spi_xfer_done;

	// Line order follows the code table: routing, converters, timers, serial units. [R10] [R11] [R12]
	// Channels C and D exist only on the quad timer, so the dual timers carry four lines. [R14] [R15] [R16] [R17]
	assign line_req = {serial_port_second_req, serial_port_first_req, spi_line1, spi_line0,
		timer_dual_second_req, timer_dual_first_req, timer_quad_first_req,
		converter_out_req, converter_in_req, event_req};

	dmadts_trigger_decode #(
		.LINE_PRESENT(LINE_PRESENT)
	) u_decode (
		.clk(clk),
		.nrst(nrst),
		.trigger_select(trigger_select),
		.line_req(line_req),
		.line_hit(line_hit),
		.hw_request(hw_request)
	);

	// Register decode.
	assign wr_ctrl = reg_wr && reg_addr == dmadts_pkg::REG_CTRL;
	assign wr_status = reg_wr && reg_addr == dmadts_pkg::REG_STATUS;
	assign wr_mode = reg_wr && reg_addr == dmadts_pkg::REG_DEST_MODE;
	assign wr_trigger = reg_wr && reg_addr == dmadts_pkg::REG_TRIGGER_SELECT;
	assign wr_low = reg_wr && reg_addr == dmadts_pkg::REG_DEST_LOW;
	assign wr_high = reg_wr && reg_addr == dmadts_pkg::REG_DEST_HIGH;
	assign soft_transfer_request = wr_ctrl && reg_wdata[dmadts_pkg::CTRL_SOFT_REQ_BIT];

	// Channel sequencing.
	assign busy = state == dmadts_pkg::CHAN_BUSY;
	assign idle_start = !busy && enable && (hw_request || soft_pend);
	assign chan_end = busy && (!enable || xfer_complete || xfer_error || search_match); // [R20] [R22]
	assign transfer_start = idle_start;
	assign channel_active_flag = busy;

	// A hardware request consumes the source flag when taken; a source interrupt on it may never be seen. [R9] [R8]
	assign req_ack = line_hit & {dmadts_pkg::NUM_LINES{idle_start}};

	always_comb begin
		next_state = state;
		unique case (state)
			dmadts_pkg::CHAN_IDLE: begin
				if (idle_start) begin
					next_state = dmadts_pkg::CHAN_BUSY; // [R20]
				end
			end
			dmadts_pkg::CHAN_BUSY: begin
				if (chan_end) begin
					next_state = dmadts_pkg::CHAN_IDLE; // [R20]
				end
			end
		endcase
	end

	// A new software request wins over its own consumption in the same cycle.
	assign next_soft_pend = soft_transfer_request ? 1'b1 : ((idle_start || !enable) ? 1'b0 : soft_pend);

	// Searching.
	assign is_search = dest_addr_mode == dmadts_pkg::DEST_MASKED_BYTE_SEARCH
		|| dest_addr_mode == dmadts_pkg::DEST_EITHER_BYTE_SEARCH
		|| dest_addr_mode == dmadts_pkg::DEST_BYTE_PAIR_SEARCH;
	// Reserved codes, and byte searches under two-byte bursts, are flagged and never match. [R1] [R19]
	assign mode_invalid = (!is_search && dest_addr_mode != dmadts_pkg::DEST_FIXED && dest_addr_mode != dmadts_pkg::DEST_INC)
		|| (burst_size == dmadts_pkg::BURST_TWO_BYTE && (dest_addr_mode == dmadts_pkg::DEST_MASKED_BYTE_SEARCH
		|| dest_addr_mode == dmadts_pkg::DEST_EITHER_BYTE_SEARCH));

	dmadts_search u_search (
		.clk(clk),
		.nrst(nrst),
		.dest_addr_mode(dest_addr_mode),
		.dest_pointer_low(dest_pointer[7:0]),
		.dest_pointer_high(dest_pointer[15:8]),
		.burst_size(burst_size),
		.restart(idle_start),
		.byte_valid(data_valid && busy),
		.byte_data(data_byte),
		.match(search_match)
	);

	// The found flag sets over a simultaneous write-one clear. [R22]
	assign next_found = search_match ? 1'b1 : ((wr_status && reg_wdata[dmadts_pkg::STATUS_FOUND_BIT]) ? 1'b0 : found);

	// Software may load the pointer only while idle, so hardware stepping has no rival.
	// Only the increment mode steps it; search modes keep it as the pattern. [R1] [R21]
	assign next_dest_pointer = (!busy && wr_low) ? {dest_pointer[15:8], reg_wdata}
		: (!busy && wr_high) ? {reg_wdata, dest_pointer[7:0]}
		: (busy && beat_done && dest_addr_mode == dmadts_pkg::DEST_INC) ? dest_pointer + 16'h0001
		: dest_pointer;

	// Read data.
	assign ctrl_value = {enable, 6'h00, burst_size};
	assign status_value = {busy, 5'h00, mode_invalid, found};
	assign next_rdata = !reg_rd ? dmadts_pkg::RST_READ_DATA
		: (reg_addr == dmadts_pkg::REG_CTRL) ? ctrl_value
		: (reg_addr == dmadts_pkg::REG_STATUS) ? status_value
		: (reg_addr == dmadts_pkg::REG_DEST_MODE) ? {5'h00, dest_addr_mode}
		: (reg_addr == dmadts_pkg::REG_TRIGGER_SELECT) ? trigger_select
		: (reg_addr == dmadts_pkg::REG_DEST_LOW) ? dest_pointer[7:0]
		: (reg_addr == dmadts_pkg::REG_DEST_HIGH) ? dest_pointer[15:8]
		: dmadts_pkg::RST_READ_DATA;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= dmadts_pkg::CHAN_IDLE;
			soft_pend <= 1'b0;
			found <= 1'b0;
			dest_pointer <= dmadts_pkg::RST_DEST_POINTER;
			reg_rdata <= dmadts_pkg::RST_READ_DATA;
		end else begin
			state <= next_state;
			soft_pend <= next_soft_pend;
			found <= next_found;
			dest_pointer <= next_dest_pointer;
			reg_rdata <= next_rdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			enable <= 1'b0;
			trigger_select <= dmadts_pkg::RST_TRIGGER_SELECT;
		end else begin
			if (wr_ctrl) begin
				enable <= reg_wdata[dmadts_pkg::CTRL_ENABLE_BIT];
			end
			if (wr_trigger) begin
				trigger_select <= reg_wdata; // [R6]
			end
		end
	end

	// Mode and burst size freeze while busy. [R2] [R19]
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dest_addr_mode <= dmadts_pkg::RST_DEST_MODE;
			burst_size <= dmadts_pkg::BURST_ONE_BYTE;
		end else if (!busy) begin
			if (wr_mode) begin
				dest_addr_mode <= reg_wdata[2:0];
			end
			if (wr_ctrl) begin
				burst_size <= reg_wdata[dmadts_pkg::CTRL_BURST_BIT];
			end
		end
	end

	property p_mode_hold;
		busy && wr_mode |=> dest_addr_mode == $past(dest_addr_mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed while busy"); // [R2]

	property p_fixed_hold;
		busy && dest_addr_mode == dmadts_pkg::DEST_FIXED |=> $stable(dest_pointer);
	endproperty
	a_fixed_hold: assert property (p_fixed_hold) else $error("fixed pointer moved"); // [R1]

	property p_inc_step;
		busy && beat_done && dest_addr_mode == dmadts_pkg::DEST_INC |=> dest_pointer == $past(dest_pointer) + 16'h0001;
	endproperty
	a_inc_step: assert property (p_inc_step) else $error("pointer did not step by one"); // [R1]

	property p_search_pattern;
		busy && is_search |=> $stable(dest_pointer);
	endproperty
	a_search_pattern: assert property (p_search_pattern) else $error("search pattern moved"); // [R21]

	property p_busy_rise;
		transfer_start |=> channel_active_flag;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy not raised after start"); // [R20]

	property p_busy_fall;
		busy && (xfer_complete || xfer_error || !enable) |=> !channel_active_flag;
	endproperty
	a_busy_fall: assert property (p_busy_fall) else $error("busy not cleared"); // [R20]

	property p_ack;
		|req_ack |-> $onehot(req_ack) && transfer_start && !busy;
	endproperty
	a_ack: assert property (p_ack) else $error("acknowledge without a start"); // [R9]

	sequence s_match_seen;
		search_match;
	endsequence
	sequence s_found_stays;
		found && !channel_active_flag;
	endsequence
	property p_found;
		s_match_seen |=> s_found_stays;
	endproperty
	a_found: assert property (p_found) else $error("match not reported"); // [R22]

	property p_read_trigger;
		reg_rd && reg_addr == dmadts_pkg::REG_TRIGGER_SELECT |=> reg_rdata == $past(trigger_select);
	endproperty
	a_read_trigger: assert property (p_read_trigger) else $error("trigger select read back wrong"); // [R6]

endmodule // dmadts_dest_trigger

/* rtl/dmadts_pkg.sv */
package dmadts_pkg;

	// Register offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h01;
	localparam logic [7:0] REG_DEST_MODE = 8'h03;
	localparam logic [7:0] REG_TRIGGER_SELECT = 8'h04;
	localparam logic [7:0] REG_DEST_LOW = 8'h0a;
	localparam logic [7:0] REG_DEST_HIGH = 8'h0b;

	// Field positions.
	localparam int CTRL_ENABLE_BIT = 7;
	localparam int CTRL_SOFT_REQ_BIT = 4;
	localparam int CTRL_BURST_BIT = 0;
	localparam int STATUS_BUSY_BIT = 7;
	localparam int STATUS_INVALID_BIT = 1;
	localparam int STATUS_FOUND_BIT = 0;

	// Values after reset.
	localparam logic [7:0] RST_TRIGGER_SELECT = 8'h00;
	localparam logic [2:0] RST_DEST_MODE = 3'h0;
	localparam logic [15:0] RST_DEST_POINTER = 16'h0000;
	localparam logic [7:0] RST_READ_DATA = 8'h00;

	// Destination addressing codes.
	localparam logic [2:0] DEST_FIXED = 3'h0;
	localparam logic [2:0] DEST_INC = 3'h1;
	localparam logic [2:0] DEST_MASKED_BYTE_SEARCH = 3'h4;
	localparam logic [2:0] DEST_EITHER_BYTE_SEARCH = 3'h5;
	localparam logic [2:0] DEST_BYTE_PAIR_SEARCH = 3'h6;

	// Burst-length codes.
	localparam logic BURST_ONE_BYTE = 1'b0;
	localparam logic BURST_TWO_BYTE = 1'b1;

	// Trigger base codes.
	localparam logic [7:0] TRIG_OFF = 8'h00;
	localparam logic [7:0] BASE_EVENT_ROUTING = 8'h01;
	localparam logic [7:0] BASE_CONVERTER_IN = 8'h10;
	localparam logic [7:0] BASE_CONVERTER_OUT = 8'h15;
	localparam logic [7:0] BASE_TIMER_QUAD_FIRST = 8'h40;
	localparam logic [7:0] BASE_TIMER_DUAL_FIRST = 8'h46;
	localparam logic [7:0] BASE_SERIAL_PERIPH = 8'h4a;
	localparam logic [7:0] BASE_SERIAL_PORT_FIRST = 8'h4c;
	localparam logic [7:0] BASE_TIMER_DUAL_SECOND = 8'h66;
	localparam logic [7:0] BASE_SERIAL_PORT_SECOND = 8'h6c;

	// Per-event offsets.
	localparam logic [7:0] OFS_CH0 = 8'h00;
	localparam logic [7:0] OFS_CH1 = 8'h01;
	localparam logic [7:0] OFS_CH2 = 8'h02;
	localparam logic [7:0] OFS_TIMER_WRAP = 8'h00;
	localparam logic [7:0] OFS_TIMER_ERROR = 8'h01;
	localparam logic [7:0] OFS_COMPARE_CHAN_A = 8'h02;
	localparam logic [7:0] OFS_COMPARE_CHAN_B = 8'h03;
	localparam logic [7:0] OFS_COMPARE_CHAN_C = 8'h04;
	localparam logic [7:0] OFS_COMPARE_CHAN_D = 8'h05;
	localparam logic [7:0] OFS_RECEIVE_DONE = 8'h00;
	localparam logic [7:0] OFS_TX_HOLDING_EMPTY = 8'h01;

	// Request lines, in line-index order.
	localparam int NUM_LINES = 26;
	localparam logic [NUM_LINES-1:0] DEFAULT_PRESENT = 26'h3ffffff;
	localparam logic [7:0] LINE_CODE [NUM_LINES] = '{
		BASE_EVENT_ROUTING + OFS_CH0, BASE_EVENT_ROUTING + OFS_CH1, BASE_EVENT_ROUTING + OFS_CH2,
		BASE_CONVERTER_IN + OFS_CH0,
		BASE_CONVERTER_OUT + OFS_CH0, BASE_CONVERTER_OUT + OFS_CH1,
		BASE_TIMER_QUAD_FIRST + OFS_TIMER_WRAP, BASE_TIMER_QUAD_FIRST + OFS_TIMER_ERROR,
		BASE_TIMER_QUAD_FIRST + OFS_COMPARE_CHAN_A, BASE_TIMER_QUAD_FIRST + OFS_COMPARE_CHAN_B,
		BASE_TIMER_QUAD_FIRST + OFS_COMPARE_CHAN_C, BASE_TIMER_QUAD_FIRST + OFS_COMPARE_CHAN_D,
		BASE_TIMER_DUAL_FIRST + OFS_TIMER_WRAP, BASE_TIMER_DUAL_FIRST + OFS_TIMER_ERROR,
		BASE_TIMER_DUAL_FIRST + OFS_COMPARE_CHAN_A, BASE_TIMER_DUAL_FIRST + OFS_COMPARE_CHAN_B,
		BASE_TIMER_DUAL_SECOND + OFS_TIMER_WRAP, BASE_TIMER_DUAL_SECOND + OFS_TIMER_ERROR,
		BASE_TIMER_DUAL_SECOND + OFS_COMPARE_CHAN_A, BASE_TIMER_DUAL_SECOND + OFS_COMPARE_CHAN_B,
		BASE_SERIAL_PERIPH + OFS_CH0, BASE_SERIAL_PERIPH + OFS_CH1,
		BASE_SERIAL_PORT_FIRST + OFS_RECEIVE_DONE, BASE_SERIAL_PORT_FIRST + OFS_TX_HOLDING_EMPTY,
		BASE_SERIAL_PORT_SECOND + OFS_RECEIVE_DONE, BASE_SERIAL_PORT_SECOND + OFS_TX_HOLDING_EMPTY
	};

	// Channel state.
	typedef enum logic {
		CHAN_IDLE,
		CHAN_BUSY
	} dmadts_chan_t;

endpackage

/* rtl/dmadts_trigger_decode.sv */
`timescale 1ns/1ps
module dmadts_trigger_decode #(
	parameter logic [dmadts_pkg::NUM_LINES-1:0] LINE_PRESENT = dmadts_pkg::DEFAULT_PRESENT
) (
	// Clock and reset, used by the checks only.
	input logic clk,
	input logic nrst,
	// Selection and request lines.
	input logic [7:0] trigger_select,
	input logic [dmadts_pkg::NUM_LINES-1:0] line_req,
	// Decoded result.
	output logic [dmadts_pkg::NUM_LINES-1:0] line_hit,
	output logic hw_request
);

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	genvar i;
	generate
		for (i = 0; i < dmadts_pkg::NUM_LINES; i++) begin : g_line
			// Each sum of base and offset is one distinct line; absent units never hit. [R13] [R7]
			assign line_hit[i] = LINE_PRESENT[i] && line_req[i] && (trigger_select == dmadts_pkg::LINE_CODE[i]);

			property p_hit_code;
				line_hit[i] |-> trigger_select == dmadts_pkg::LINE_CODE[i] && LINE_PRESENT[i];
			endproperty
			a_hit_code: assert property (p_hit_code) else $error("hit on a line whose code is not selected"); // [R13]
		end
	endgenerate

	// A zero selection matches no line code, so only software can start. [R6]
	assign hw_request = |line_hit;

	property p_off_soft_only;
		trigger_select == dmadts_pkg::TRIG_OFF |-> !hw_request;
	endproperty
	a_off_soft_only: assert property (p_off_soft_only) else $error("hardware request with triggering off"); // [R6]

endmodule // dmadts_trigger_decode

/* rtl/dmadts_search.sv */
`timescale 1ns/1ps
module dmadts_search (
	// Clock and reset.
	input logic clk,
	input logic nrst,
	// Configuration.
	input logic [2:0] dest_addr_mode,
	input logic [7:0] dest_pointer_low,
	input logic [7:0] dest_pointer_high,
	input logic burst_size,
	// Byte stream.
	input logic restart,
	input logic byte_valid,
	input logic [7:0] byte_data,
	// Result.
	output logic match
);

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	logic first_hit;
	logic one_byte;
	logic masked_hit;
	logic either_hit;
	logic pair_hit;

	assign one_byte = burst_size == dmadts_pkg::BURST_ONE_BYTE; // [R19]
	assign masked_hit = one_byte && (dest_addr_mode == dmadts_pkg::DEST_MASKED_BYTE_SEARCH)
		&& (((byte_data ^ dest_pointer_low) & dest_pointer_high) == 8'h00); // [R3]
	assign either_hit = one_byte && (dest_addr_mode == dmadts_pkg::DEST_EITHER_BYTE_SEARCH)
		&& (byte_data == dest_pointer_low || byte_data == dest_pointer_high); // [R4]
	assign pair_hit = (dest_addr_mode == dmadts_pkg::DEST_BYTE_PAIR_SEARCH) && first_hit
		&& (byte_data == dest_pointer_high); // [R5]
	assign match = byte_valid && (masked_hit || either_hit || pair_hit);

	// Any byte in between breaks the pair, since the flag is rewritten on every byte. [R5]
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			first_hit <= 1'b0;
		end else if (restart) begin
			first_hit <= 1'b0;
		end else if (byte_valid) begin
			first_hit <= (dest_addr_mode == dmadts_pkg::DEST_BYTE_PAIR_SEARCH) && (byte_data == dest_pointer_low);
		end
	end

	property p_masked;
		byte_valid && one_byte && dest_addr_mode == dmadts_pkg::DEST_MASKED_BYTE_SEARCH
			|-> match == (((byte_data ^ dest_pointer_low) & dest_pointer_high) == 8'h00);
	endproperty
	a_masked: assert property (p_masked) else $error("masked search result wrong"); // [R3]

	property p_either;
		byte_valid && dest_addr_mode == dmadts_pkg::DEST_EITHER_BYTE_SEARCH
			|-> match == (one_byte && (byte_data == dest_pointer_low || byte_data == dest_pointer_high));
	endproperty
	a_either: assert property (p_either) else $error("either-byte search result wrong"); // [R4]

	sequence s_pair_first;
		byte_valid && !restart && dest_addr_mode == dmadts_pkg::DEST_BYTE_PAIR_SEARCH && byte_data == dest_pointer_low;
	endsequence
	sequence s_pair_second;
		byte_valid && dest_addr_mode == dmadts_pkg::DEST_BYTE_PAIR_SEARCH && byte_data == dest_pointer_high;
	endsequence
	property p_pair;
		s_pair_first ##1 s_pair_second |-> match;
	endproperty
	a_pair: assert property (p_pair) else $error("byte pair not found"); // [R5]

endmodule // dmadts_search

/* dv/dmadts_periph_model.sv */
`timescale 1ns/1ps
module dmadts_periph_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Raise pulses and acknowledges, by line index.
	input wire logic [dmadts_pkg::NUM_LINES-1:0] raise,
	input wire logic [dmadts_pkg::NUM_LINES-1:0] req_ack,
	// Held request flags.
	output logic [dmadts_pkg::NUM_LINES-1:0] flags
);
	// A flag is only ever cleared by the channel, so an untaken request waits as long as it must.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~req_ack) | raise;
		end
	end
endmodule // dmadts_periph_model

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic spi_buffered = 1'b1;
	logic beat_done = 1'b0;
	logic xfer_complete = 1'b0;
	logic xfer_error = 1'b0;
	logic data_valid = 1'b0;
	logic [7:0] data_byte = 8'h00;
	logic [25:0] raise = 26'h0;
	logic [25:0] flags;
	logic [25:0] req_ack;
	logic [25:0] model_ack;
	logic [7:0] reg_rdata;
	logic transfer_start;
	logic channel_active_flag;
	logic search_match;
	logic [15:0] dest_pointer;
	logic [2:0] dest_addr_mode;
	logic burst_size;
	int error_cnt = 0;
	int checks = 0;
	logic [7:0] codes [26] = '{8'h01, 8'h02, 8'h03, 8'h10, 8'h15, 8'h16, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44,
		8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h66, 8'h67, 8'h68, 8'h69, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h6c, 8'h6d};

	always #2.5 clk = ~clk;

	// Line 11 is left out of this build so that an absent source can be selected.
	dmadts_dest_trigger #(.LINE_PRESENT(26'h3fff7ff)) dmadts_dest_trigger_inst (
		.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .event_req(flags[2:0]), .converter_in_req(flags[3]), .converter_out_req(flags[5:4]),
		.timer_quad_first_req(flags[11:6]), .timer_dual_first_req(flags[15:12]),
		.timer_dual_second_req(flags[19:16]), .spi_buffered(spi_buffered), .spi_xfer_done(flags[20] | flags[21]),
		.spi_receive_done(flags[20]), .spi_tx_holding_empty(flags[21]), .serial_port_first_req(flags[23:22]),
		.serial_port_second_req(flags[25:24]), .req_ack(req_ack), .beat_done(beat_done),
		.xfer_complete(xfer_complete), .xfer_error(xfer_error), .data_valid(data_valid), .data_byte(data_byte),
		.transfer_start(transfer_start), .channel_active_flag(channel_active_flag), .search_match(search_match),
		.dest_pointer(dest_pointer), .dest_addr_mode(dest_addr_mode), .burst_size(burst_size));

	// In standard mode both serial peripheral selections share one transfer-done flag, so taking either clears it.
	assign model_ack = req_ack | ({26{!spi_buffered && |req_ack[21:20]}} & 26'h0300000);

	dmadts_periph_model dmadts_periph_model_inst (.clk(clk), .nrst(nrst), .raise(raise), .req_ack(model_ack),
		.flags(flags));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(name, reg_rdata, exp);
	endtask

	task automatic wait_start(output bit seen);
		seen = 1'b0;
		repeat (12) begin
			@(negedge clk);
			if (transfer_start === 1'b1) begin
				seen = 1'b1;
				break;
			end
		end
	endtask

	task automatic end_xfer(input bit err);
		@(posedge clk);
		if (err) xfer_error <= 1'b1;
		else xfer_complete <= 1'b1;
		@(posedge clk);
		xfer_error <= 1'b0;
		xfer_complete <= 1'b0;
		@(negedge clk);
		chk("busy after end", channel_active_flag, 0);
	endtask

	task automatic beats(input logic [2:0] mode, input logic [15:0] exp);
		bit ok;
		wr(dmadts_pkg::REG_DEST_MODE, {5'h00, mode});
		wr(dmadts_pkg::REG_CTRL, 8'h90);
		wait_start(ok);
		wr(dmadts_pkg::REG_DEST_MODE, {5'h00, ~mode});
		rdc("mode held while busy", dmadts_pkg::REG_DEST_MODE, {5'h00, mode});
		chk("beats start", ok, 1);
		chk("mode port", dest_addr_mode, mode);
		@(posedge clk);
		beat_done <= 1'b1;
		repeat (2) @(posedge clk);
		beat_done <= 1'b0;
		@(negedge clk);
		chk("pointer", dest_pointer, exp);
		end_xfer(1'b0);
	endtask

	task automatic search(input logic [2:0] mode, input logic [7:0] lo, input logic [7:0] hi,
		input logic [7:0] ctrl, input logic [31:0] bytes, input int hit);
		bit ok;
		wr(dmadts_pkg::REG_DEST_LOW, lo);
		wr(dmadts_pkg::REG_DEST_HIGH, hi);
		wr(dmadts_pkg::REG_DEST_MODE, {5'h00, mode});
		wr(dmadts_pkg::REG_STATUS, 8'h01);
		wr(dmadts_pkg::REG_CTRL, ctrl);
		wait_start(ok);
		chk("search start", ok, 1);
		chk("burst port", burst_size, ctrl[0]);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			data_valid <= 1'b1;
			data_byte <= bytes[31-8*k -: 8];
			@(negedge clk);
			chk("match", search_match, k == hit);
			if (k == hit) break;
		end
		@(posedge clk);
		data_valid <= 1'b0;
		if (hit > 3) end_xfer(1'b0);
		chk("pattern kept", dest_pointer, {hi, lo});
		rdc("status", dmadts_pkg::REG_STATUS, {6'h00, ctrl[0] && mode != 3'h6, hit < 4});
	endtask

	task automatic final_report;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// The whole run takes about five hundred cycles; this leaves ample margin.
	initial begin
		#100000;
		error_cnt++;
		final_report();
	end

	initial begin
		bit ok;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rdc("trigger reset", dmadts_pkg::REG_TRIGGER_SELECT, 8'h00);
		rdc("mode reset", dmadts_pkg::REG_DEST_MODE, 8'h00);
		rdc("unmapped", 8'h20, 8'h00);
		wr(dmadts_pkg::REG_TRIGGER_SELECT, 8'ha5);
		rdc("trigger rw", dmadts_pkg::REG_TRIGGER_SELECT, 8'ha5);
		wr(dmadts_pkg::REG_TRIGGER_SELECT, 8'h00);
		wr(dmadts_pkg::REG_CTRL, 8'h80);
		@(posedge clk);
		raise <= 26'h1;
		@(posedge clk);
		raise <= 26'h0;
		wait_start(ok);
		chk("start with selection off", ok, 0);
		for (int i = 0; i < 26; i++) begin
			wr(dmadts_pkg::REG_CTRL, 8'h00);
			wr(dmadts_pkg::REG_TRIGGER_SELECT, codes[i]);
			@(posedge clk);
			raise <= 26'h1 << i;
			@(posedge clk);
			raise <= 26'h0;
			wr(dmadts_pkg::REG_CTRL, 8'h80);
			wait_start(ok);
			chk("start", ok, i != 11);
			if (i != 11) begin
				chk("ack", req_ack, 26'h1 << i);
				end_xfer(i[0]);
				chk("flag consumed", flags[i], 0);
			end
		end
		// In standard mode selection 0x4b follows the one transfer-done line, here raised through flag 20.
		wr(dmadts_pkg::REG_CTRL, 8'h00);
		spi_buffered <= 1'b0;
		wr(dmadts_pkg::REG_TRIGGER_SELECT, 8'h4b);
		@(posedge clk);
		raise <= 26'h1 << 20;
		@(posedge clk);
		raise <= 26'h0;
		wr(dmadts_pkg::REG_CTRL, 8'h80);
		wait_start(ok);
		chk("spi standard start", ok, 1);
		end_xfer(1'b0);
		chk("spi flag consumed", flags[20], 0);
		wr(dmadts_pkg::REG_TRIGGER_SELECT, 8'h00);
		wr(dmadts_pkg::REG_DEST_LOW, 8'h34);
		wr(dmadts_pkg::REG_DEST_HIGH, 8'h12);
		beats(3'h1, 16'h1236);
		beats(3'h0, 16'h1236);
		foreach (codes[j]) if (j < 3) begin
			wr(dmadts_pkg::REG_DEST_MODE, {5'h00, j == 2 ? 3'h7 : 3'h2 + j[2:0]});
			rdc("reserved mode", dmadts_pkg::REG_STATUS, 8'h02);
		end
		search(3'h4, 8'h5a, 8'h0f, 8'h90, 32'h553baa00, 2);
		search(3'h4, 8'h5a, 8'h0f, 8'h91, 32'haaaaaaaa, 4);
		search(3'h5, 8'h11, 8'h22, 8'h90, 32'h33221100, 1);
		search(3'h6, 8'h33, 8'h44, 8'h90, 32'h33103344, 3);
		search(3'h6, 8'h33, 8'h44, 8'h91, 32'h44334400, 2);
		final_report();
	end
endmodule // testbench
